// ### asm_pkg.sv
package asm_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_PS = 5000;

  // Times in ps; least times and longest times all round up
  localparam int WRITE_PULSE_PS = 35000;
  localparam int WRITE_DATA_SETUP_TIME_PS = 25000;
  localparam int WRITE_TO_FLOAT_TIME_PS = 18000;
  localparam int ADDR_SETUP_PS = 0;
  localparam int READ_ACCESS_PS = 45000;
  localparam int CYCLE_PS = 45000;
  localparam int HZ_PS = 18000;

  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int FLOAT_SETUP_CYC = cyc_up(WRITE_TO_FLOAT_TIME_PS + WRITE_DATA_SETUP_TIME_PS);
  localparam int WR_PULSE_CYC = (cyc_up(WRITE_PULSE_PS) > FLOAT_SETUP_CYC) ?
                                cyc_up(WRITE_PULSE_PS) : FLOAT_SETUP_CYC;
  localparam int WR_FLOAT_CYC = cyc_up(WRITE_TO_FLOAT_TIME_PS);
  localparam int SETUP_CYC = cyc_up(ADDR_SETUP_PS);
  localparam int RD_ACCESS_CYC = cyc_up(READ_ACCESS_PS) + 1;
  localparam int RECOVER_CYC = cyc_up(HZ_PS);
  localparam int CYCLE_CYC = cyc_up(CYCLE_PS);
  localparam int CNT_W = 5;

  localparam logic [1:0] LANES_NONE = 2'h3;
  // Upper lane off, lower lane on: the only pattern used for accesses in 8-bit mode
  localparam logic [1:0] LANES_LOW = 2'h2;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lane_n;
  } asm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic corrected;
  } asm_rsp_t;

  typedef struct packed {
    logic select_low_active;
    logic select_high_active;
    logic write_n;
    logic out_en_n;
    logic upper_lane_en_n;
    logic lower_lane_en_n;
    logic [ADDR_W-1:0] addr;
  } asm_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WSETUP = 3'h1,
    ST_WPULSE = 3'h2,
    ST_WHOLD = 3'h3,
    ST_RACCESS = 3'h4,
    ST_RECOVER = 3'h5
  } asm_state_t;

endpackage

// ### asm_host.sv
// Contract
// - Selected only while low-active select low and high-active select high.
// - Write is overlap of strobe low, selects active, a lane enabled.
// - Host holds write data valid around the edge ending the write.
// - Lane-ended write with output enabled lasts float time plus setup.
// - Host never drives data while the device may be driving.
// - Width select high gives 16-bit, low gives 8-bit low lane.
// - Both lane enables high put the device in standby.
`timescale 1ns/1ps
`default_nettype none
module asm_host
  import asm_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wide_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire asm_req_t req,
  output logic rsp_valid,
  output asm_rsp_t rsp,
  output asm_pins_t pins,
  output logic byte_mode_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic err_in,
  input wire logic err_oe_n_unused
);

  ////////////////////////////////////////////////////////////////////////////
  asm_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  asm_req_t req_q;
  logic data_drive_q;
  logic sel_q;
  logic we_q;
  logic oe_q;
  logic [1:0] lane_q;
  logic last;
  logic take;

  assign last = (cnt_q == '0);
  assign req_ready = (state_q == ST_IDLE);
  assign take = req_valid && req_ready;

  assign byte_mode_n = wide_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; every timed phase ends when the phase counter reaches zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= req.write ? ST_WSETUP : ST_RACCESS;
          end
        end
        ST_WSETUP: begin
          if (last) begin
            state_q <= ST_WPULSE;
          end
        end
        ST_WPULSE: begin
          if (last) begin
            state_q <= ST_WHOLD;
          end
        end
        ST_WHOLD: begin
          state_q <= ST_RECOVER;
        end
        ST_RACCESS: begin
          if (last) begin
            state_q <= ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (last) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter, loaded on entry to each timed phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (take) begin
      cnt_q <= req.write ? CNT_W'(SETUP_CYC - 1) : CNT_W'(RD_ACCESS_CYC - 1);
    end else if (state_q == ST_WSETUP && last) begin
      cnt_q <= CNT_W'(WR_PULSE_CYC - 1);
    end else if (state_q == ST_WHOLD || (state_q == ST_RACCESS && last)) begin
      // Recovery lets the device float its outputs before the next access
      cnt_q <= CNT_W'(RECOVER_CYC - 1);
    end else if (!last) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request held for the whole access; address and write data come from here
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_q <= '0;
    end else if (take) begin
      req_q <= req;
      if (!wide_mode) begin
        req_q.lane_n <= LANES_LOW;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control pins registered so they never glitch

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= (state_q inside {ST_WSETUP, ST_WPULSE, ST_RACCESS}) || take;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      we_q <= 1'b0;
    end else begin
      we_q <= (state_q == ST_WSETUP && last) || (state_q == ST_WPULSE && !last);
    end
  end

  // Output enable only for reads, so a write never meets driven device pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (take && !req.write) || (state_q == ST_RACCESS && !last);
    end
  end

  // lanes off means standby between accesses
  // On reads the lanes drop one edge before select; both lanes off is already standby
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lane_q <= LANES_NONE;
    end else if (take) begin
      lane_q <= wide_mode ? req.lane_n : LANES_LOW;
    end else if (state_q == ST_WHOLD || (state_q == ST_RACCESS && last)) begin
      lane_q <= LANES_NONE;
    end
  end

  // data stays until after strobe rise; only in write states
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_drive_q <= 1'b0;
    end else begin
      // output enable stays high while driving
      data_drive_q <= (state_q == ST_WSETUP) || (state_q == ST_WPULSE);
    end
  end

  // One driver for the whole pin bundle
  assign pins = '{
    select_low_active: ~sel_q,
    select_high_active: sel_q,
    write_n: ~we_q,
    out_en_n: ~oe_q,
    upper_lane_en_n: lane_q[1],
    lower_lane_en_n: lane_q[0],
    addr: req_q.addr
  };
  assign data_out = req_q.wdata;
  assign data_oe_n = ~data_drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // Answer pulses for one cycle only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state_q == ST_RACCESS) && last;
    end
  end

  // Read data taken in the last access cycle and held until the next read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsp <= '0;
    end else if (state_q == ST_RACCESS && last) begin
      rsp.rdata[BYTE_W-1:0] <= req_q.lane_n[0] ? '0 : data_in[BYTE_W-1:0];
      rsp.rdata[DATA_W-1:BYTE_W] <= (req_q.lane_n[1] || !wide_mode) ? '0 :
                                     data_in[DATA_W-1:BYTE_W];
      rsp.corrected <= err_in;
    end
  end

endmodule
`default_nettype wire

// ### asm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asm_mem_model
  import asm_pkg::*;
(
  input wire asm_pins_t pins,
  input wire logic byte_mode_n,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] flip,
  output logic [DATA_W-1:0] dq,
  output logic err
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] chk [int];
  logic [DATA_W-1:0] q;
  logic [1:0] ln;
  logic sel, rd, bad;
  assign ln = byte_mode_n ? {pins.upper_lane_en_n, pins.lower_lane_en_n} : 2'h2;
  assign sel = !pins.select_low_active && pins.select_high_active && ln != 2'h3;
  assign rd = sel && pins.write_n && !pins.out_en_n;
  // write window and check field
  // Derived selects are listed too, else a read could see them stale
  always @(pins or byte_mode_n or wdata or flip or sel or rd or ln) begin
    q = chk.exists(pins.addr) ? chk[pins.addr] : 16'h0000;
    if (sel && !pins.write_n) begin
      if (!ln[0]) q[7:0] = wdata[7:0];
      if (!ln[1]) q[15:8] = wdata[15:8];
      chk[pins.addr] = q;
      mem[pins.addr] = q ^ flip;
    end
    bad = rd && chk.exists(pins.addr) && mem[pins.addr] !== q;
  end
  // lanes, released lanes show the inverse
  assign dq = {rd && !ln[1] ? q[15:8] : ~q[15:8], rd && !ln[0] ? q[7:0] : ~q[7:0]};
  assign err = rd ? bad : 1'b1;
endmodule
`default_nettype wire

// ### asm_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asm_host_monitor
  import asm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wide_mode,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire asm_req_t req,
  input wire logic rsp_valid,
  input wire asm_pins_t pins,
  input wire logic byte_mode_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic sel;
  assign sel = !pins.select_low_active && pins.select_high_active;
  property p_no_clash; !data_oe_n |-> pins.out_en_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives during read");
  property p_wsel; !pins.write_n |-> sel && !(pins.upper_lane_en_n && pins.lower_lane_en_n);
  endproperty
  a_wsel: assert property (p_wsel) else $error("strobe low outside select");
  property p_pulse; $fell(pins.write_n) |-> !pins.write_n[*8] ##1 !pins.write_n ##1 pins.write_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse not 9 cycles");
  property p_hold; !pins.write_n |=> !data_oe_n && $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("write data moved");
  property p_width; byte_mode_n == wide_mode; endproperty
  a_width: assert property (p_width) else $error("width pin wrong");
  property p_narrow; sel && !wide_mode |-> pins.upper_lane_en_n &&
    (!pins.lower_lane_en_n || (pins.write_n && pins.out_en_n));
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow lanes wrong");
  property p_rsel; !pins.out_en_n |-> sel && !(pins.upper_lane_en_n && pins.lower_lane_en_n);
  endproperty
  a_rsel: assert property (p_rsel) else $error("read outside select");
  property p_answer; req_valid && req_ready && !req.write |-> ##11 rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("read answer late");
endmodule
bind asm_host asm_host_monitor u_mon (.clk(clk), .nrst(nrst), .wide_mode(wide_mode),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .pins(pins), .byte_mode_n(byte_mode_n), .data_out(data_out), .data_oe_n(data_oe_n));
`default_nettype wire

// ### asm_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module asm_host_tb
  import asm_pkg::*;
;
  typedef struct packed {logic w; logic wd; logic [ADDR_W-1:0] a; logic [1:0] ln;
    logic [DATA_W-1:0] d;} asm_row_t;
  logic clk = 0, nrst = 0, wide = 1, req_valid = 0, req_ready, rsp_valid, byte_mode_n;
  logic data_oe_n, err;
  asm_req_t req = '0;
  asm_rsp_t rsp;
  asm_pins_t pins;
  logic [DATA_W-1:0] dq, data_out, bus, flip = '0;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  asm_row_t rows [9] = '{'{1, 1, 5, 0, 16'h1234}, '{0, 1, 5, 0, 16'h1234},
    '{1, 1, 5, 2, 16'habcd}, '{0, 1, 5, 1, 16'h1200}, '{0, 1, 5, 2, 16'h00cd},
    '{1, 1, 6, 0, 16'hffff}, '{1, 0, 6, 0, 16'h77ee}, '{0, 0, 6, 0, 16'h00ee},
    '{0, 1, 6, 0, 16'hffee}};
  // Released host bus shows the inverse, so early release corrupts the write
  assign bus = data_oe_n ? ~data_out : data_out;
  asm_host dut (.clk(clk), .nrst(nrst), .wide_mode(wide), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .byte_mode_n(byte_mode_n), .data_in(dq), .data_out(data_out), .data_oe_n(data_oe_n),
    .err_in(err), .err_oe_n_unused(1'b1));
  asm_mem_model mem (.pins(pins), .byte_mode_n(byte_mode_n), .wdata(bus), .flip(flip),
    .dq(dq), .err(err));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(input asm_row_t r, input logic ce);
    @(posedge clk);
    req_valid <= 1'b1;
    wide <= r.wd;
    req <= '{r.w, r.a, r.d, r.ln};
    @(posedge clk);
    req_valid <= 1'b0;
    if (!r.w) begin
      do @(negedge clk); while (!rsp_valid);
      `CHK("rdata", r.d, rsp.rdata)
      `CHK("corrected", ce, rsp.corrected)
    end
    do @(negedge clk); while (!req_ready);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK("deselect", 1'b1, pins.select_low_active)
    `CHK("lanes off", 1'b1, pins.upper_lane_en_n & pins.lower_lane_en_n)
    $display("test reset done");
    foreach (rows[i]) op(rows[i], 1'b0);
    $display("test rows done");
    @(posedge clk) flip <= 16'h0010;
    op('{1, 1, 9, 0, 16'h5555}, 1'b0);
    @(posedge clk) flip <= 16'h0000;
    op('{0, 1, 9, 0, 16'h5555}, 1'b1);
    $display("test correction done");
    // Reset in the middle of a read must drop every strobe at the next edge
    @(posedge clk);
    req_valid <= 1'b1;
    wide <= 1'b1;
    req <= '{1'b0, 19'h5, 16'h0, 2'h0};
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK("mid deselect", 1'b0, pins.select_high_active)
    `CHK("mid lanes off", 1'b1, pins.upper_lane_en_n & pins.lower_lane_en_n)
    `CHK("mid strobes off", 1'b1, pins.out_en_n & pins.write_n & data_oe_n)
    @(posedge clk) nrst <= 1'b1;
    op('{0, 1, 5, 0, 16'h12cd}, 1'b0);
    $display("test mid reset done");
    summarize();
  end
endmodule
`default_nettype wire
